/* spw_map.svh */
// Constants of the serial wiper-control link: fields, opcodes, timing, host map
`ifndef SPW_MAP_SVH
`define SPW_MAP_SVH
`define SPW_CLK_NS 100
`define SPW_NV_WRITE_NS 10000000
`define SPW_NV_WRITE_CYC (`SPW_NV_WRITE_NS / `SPW_CLK_NS)
`define SPW_DEV_TYPE_DEFAULT 4'h9
`define SPW_SETTING_RESET 10'h000
`define SPW_ID_TYPE_MSB 7
`define SPW_ID_TYPE_LSB 4
`define SPW_ID_ADDR_MSB 3
`define SPW_ID_ADDR_LSB 2
`define SPW_ID_RW 0
`define SPW_INS_MSB 7
`define SPW_INS_LSB 5
`define SPW_SEL_MSB 3
`define SPW_SEL_LSB 2
`define SPW_OP_RD_WIPER 4'hC
`define SPW_OP_WR_WIPER 4'h5
`define SPW_OP_RD_SET 4'hD
`define SPW_OP_WR_SET 4'h6
`define SPW_OP_CP_SET_WIPER 4'hE
`define SPW_OP_CP_WIPER_SET 4'h7
`define SPW_OP_RD_STATUS 4'hA
`define SPW_HALF_CYC 4'h8
`define SPW_AXI_AW 5
`define SPW_REG_CMD 5'h00
`define SPW_REG_STATUS 5'h04
`define SPW_REG_RDATA 5'h08
`define SPW_REG_CTRL 5'h0C
`define SPW_CMD_LONG 31
`define SPW_CTRL_PAUSE 0
`define SPW_CTRL_GUARD 1
`define SPW_RESP_OKAY 2'h0
`define SPW_RESP_SLVERR 2'h2
`endif

/* spw_pkg.sv */
// Types shared by both ends of the serial wiper-control link
`default_nettype none
package spw_pkg;
  typedef enum logic [1:0] {DS_OFF, DS_IDLE, DS_RUN, DS_IGNORE} spw_dev_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_LEAD, HS_SHIFT, HS_TAIL} spw_host_state_t;
endpackage
`default_nettype wire

/* spw_if.sv */
// Serial link wires between the controller end and the wiper device end
`timescale 1ns/10ps
`default_nettype none
interface spw_if;
  logic cs_n;
  logic sck;
  logic si;
  logic pause_n;
  logic write_guard_n;
  logic so;
  logic so_oe_n;
  modport host (output cs_n, output sck, output si, output pause_n, output write_guard_n,
                input so, input so_oe_n);
  modport dev (input cs_n, input sck, input si, input pause_n, input write_guard_n,
               output so, output so_oe_n);
endinterface
`default_nettype wire

/* spw_tap_decode.sv */
// One-hot tap switch decoder for the wiper position
`timescale 1ns/10ps
`default_nettype none
module spw_tap_decode (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] position_i,
  output logic [1023:0] tap_select_o
);
  // Registered so a position change never shows two switches on at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_select_o <= 1024'h1;
    end else begin
      tap_select_o <= 1024'h1 << position_i;
    end
  end
endmodule // spw_tap_decode
`default_nettype wire

/* spw_device.sv */
// Wiper device end: serial slave, wiper latch, four stored settings
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Read bits leave on falling serial clock
// - Input bits sampled on rising serial clock
// - Pause while clock low freezes the sequence
// - Master resumes with pause high, clock low
// - Chip select high: output off, standby once no setting save runs
// - Chip select low enables the device
// - No operation before first select fall
// - Write guard low blocks stored-setting writes
// - Continue only when address bits match straps
// - Master keeps select low, pause, guard high
// - Output driven only while shifting read data
// - Wiper latch decoded to one-hot tap
// - Write-wiper instruction loads latch from host
// - Copy instruction moves setting into latch
// - Reset recalls setting zero into latch
// - Latch is volatile, defined by recall
// - Four 10-bit settings, host read/write
// - Copy either way, latch and any setting
// - Setting write completes within 10 ms
// - First byte: type, address, direction
// - Second byte: instruction and register select
// - Setting save starts when select rises
// - Write-pending bit readable, high while writing
`include "spw_map.svh"
module spw_device #(
  parameter logic [3:0] DEV_TYPE = `SPW_DEV_TYPE_DEFAULT, // Arbitrary value
  parameter int NV_WRITE_CYC = `SPW_NV_WRITE_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  spw_if.dev LINK,
  input wire logic ADDR_STRAP_1_I,
  input wire logic ADDR_STRAP_0_I,
  output logic [9:0] WIPER_O,
  output logic [1023:0] TAP_SELECT_O,
  output logic NV_WRITE_PENDING_O,
  output logic STANDBY_O
);
  import spw_pkg::*;
  localparam int NV_W = $clog2(NV_WRITE_CYC + 1);

  // ************************************************
  // Pin synchronisers and edge detection
  // ************************************************
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic cs_prev;
  logic sck_prev;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      // Reset value has select high and clock low, so no false clock edge follows reset
      pin_s1 <= 7'h5C;
      pin_s2 <= 7'h5C;
      cs_prev <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      pin_s1 <= {LINK.cs_n, LINK.sck, LINK.si, LINK.pause_n, LINK.write_guard_n,
                 ADDR_STRAP_1_I, ADDR_STRAP_0_I};
      pin_s2 <= pin_s1;
      cs_prev <= pin_s2[6];
      sck_prev <= pin_s2[5];
    end
  end
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic pause_s;
  logic guard_s;
  logic [1:0] strap_s;
  assign cs_n_s = pin_s2[6];
  assign sck_s = pin_s2[5];
  assign si_s = pin_s2[4];
  assign pause_s = pin_s2[3];
  assign guard_s = pin_s2[2];
  assign strap_s = pin_s2[1:0];

  spw_dev_state_t state;
  spw_dev_state_t next_state;
  logic paused;
  logic active;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_fall = cs_prev & ~cs_n_s;
  assign cs_rise = ~cs_prev & cs_n_s;
  assign active = (state == DS_RUN) & ~paused & ~cs_n_s;
  assign sck_rise = active & ~sck_prev & sck_s;
  assign sck_fall = active & sck_prev & ~sck_s;

  // ************************************************
  // Sequence state
  // ************************************************
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] rx_sr;
  logic [7:0] rx_byte;
  logic byte_done;
  logic id_ok;
  assign rx_byte = {rx_sr[6:0], si_s};
  assign byte_done = sck_rise & (bit_cnt == 3'h7);
  assign id_ok = (rx_byte[`SPW_ID_TYPE_MSB:`SPW_ID_TYPE_LSB] == DEV_TYPE) &&
                 (rx_byte[`SPW_ID_ADDR_MSB:`SPW_ID_ADDR_LSB] == strap_s);

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state <= DS_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      DS_OFF, DS_IDLE: begin
        if (cs_fall) begin
          next_state = DS_RUN;
        end
      end
      DS_RUN: begin
        if (cs_n_s) begin
          next_state = DS_IDLE;
        end else if (byte_done && byte_cnt == 3'h0 && !id_ok) begin
          next_state = DS_IGNORE;
        end
      end
      DS_IGNORE: begin
        if (cs_n_s) begin
          next_state = DS_IDLE;
        end
      end
      default: next_state = DS_IDLE;
    endcase
  end

  // Pause is only taken or released while the clock is low
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || state != DS_RUN) begin
      paused <= 1'b0;
    end else if (!sck_s) begin
      paused <= ~pause_s;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || state != DS_RUN) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      rx_sr <= 8'h00;
    end else if (sck_rise) begin
      rx_sr <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && byte_cnt != 3'h4) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  // ************************************************
  // Command decode
  // ************************************************
  logic rw;
  logic [3:0] op;
  logic [1:0] sel;
  logic [7:0] data_lo;
  logic [3:0] cur_op;
  logic [1:0] cur_sel;
  logic instr_done;
  logic last;
  logic is_read;
  logic [9:0] full_data;
  assign instr_done = byte_done & (byte_cnt == 3'h1);
  assign last = byte_done & (byte_cnt == 3'h3);
  assign cur_op = (byte_cnt == 3'h1) ? {rw, rx_byte[`SPW_INS_MSB:`SPW_INS_LSB]} : op;
  assign cur_sel = (byte_cnt == 3'h1) ? rx_byte[`SPW_SEL_MSB:`SPW_SEL_LSB] : sel;
  assign is_read = (cur_op == `SPW_OP_RD_WIPER) || (cur_op == `SPW_OP_RD_SET) ||
                   (cur_op == `SPW_OP_RD_STATUS);
  assign full_data = {rx_byte[1:0], data_lo};

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rw <= 1'b0;
      op <= 4'h0;
      sel <= 2'h0;
      data_lo <= 8'h00;
    end else if (byte_done) begin
      if (byte_cnt == 3'h0) begin
        rw <= rx_byte[`SPW_ID_RW];
      end
      if (byte_cnt == 3'h1) begin
        op <= cur_op;
        sel <= cur_sel;
      end
      if (byte_cnt == 3'h2) begin
        data_lo <= rx_byte;
      end
    end
  end

  // ************************************************
  // Wiper latch and stored settings
  // ************************************************
  logic [9:0] wiper;
  logic recall;
  logic [9:0] setting [4];
  logic nv_write_pending;
  logic [NV_W-1:0] nv_cnt;
  logic [1:0] nv_sel;
  logic [9:0] nv_data;
  logic pend;
  logic [1:0] pend_sel;
  logic [9:0] pend_data;

  // Settings reset only with RST_I, which stands in for first power-up
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      wiper <= `SPW_SETTING_RESET;
      recall <= 1'b1;
    end else begin
      recall <= 1'b0;
      if (recall) begin
        wiper <= setting[0];
      end else if (last && op == `SPW_OP_WR_WIPER) begin
        wiper <= full_data;
      end else if (instr_done && cur_op == `SPW_OP_CP_SET_WIPER) begin
        wiper <= setting[cur_sel];
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || cs_fall) begin
      pend <= 1'b0;
      pend_sel <= 2'h0;
      pend_data <= 10'h000;
    end else if (!guard_s) begin
      pend <= 1'b0;
    end else if (last && op == `SPW_OP_WR_SET) begin
      pend <= 1'b1;
      pend_sel <= sel;
      pend_data <= full_data;
    end else if (instr_done && cur_op == `SPW_OP_CP_WIPER_SET) begin
      pend <= 1'b1;
      pend_sel <= cur_sel;
      pend_data <= wiper;
    end
  end

  // A second save requested while one runs is dropped
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      nv_write_pending <= 1'b0;
      nv_cnt <= '0;
      nv_sel <= 2'h0;
      nv_data <= 10'h000;
    end else if (nv_write_pending) begin
      if (nv_cnt == '0) begin
        nv_write_pending <= 1'b0;
      end else begin
        nv_cnt <= nv_cnt - NV_W'(1);
      end
    end else if (cs_rise && pend && guard_s && state == DS_RUN) begin
      nv_write_pending <= 1'b1;
      nv_cnt <= NV_W'(NV_WRITE_CYC - 1);
      nv_sel <= pend_sel;
      nv_data <= pend_data;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < 4; i++) begin
        setting[i] <= `SPW_SETTING_RESET;
      end
    end else if (nv_write_pending && nv_cnt == '0) begin
      setting[nv_sel] <= nv_data;
    end
  end

  // ************************************************
  // Read data path
  // ************************************************
  logic [9:0] out_word;
  logic [7:0] tx_sr;
  logic [1:0] tx_hi;
  logic tx_armed;
  logic drive_on;
  logic so_q;
  always_comb begin
    case (cur_op)
      `SPW_OP_RD_WIPER: out_word = wiper;
      `SPW_OP_RD_SET: out_word = setting[cur_sel];
      `SPW_OP_RD_STATUS: out_word = {9'h000, nv_write_pending};
      default: out_word = 10'h000;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || state != DS_RUN) begin
      tx_sr <= 8'h00;
      tx_hi <= 2'h0;
      tx_armed <= 1'b0;
      drive_on <= 1'b0;
      so_q <= 1'b0;
    end else if (instr_done && is_read) begin
      tx_sr <= out_word[7:0];
      tx_hi <= out_word[9:8];
      tx_armed <= 1'b1;
    end else if (byte_done && byte_cnt == 3'h2 && tx_armed) begin
      tx_sr <= {6'h00, tx_hi};
    end else if (last) begin
      tx_armed <= 1'b0;
      drive_on <= 1'b0;
    end else if (sck_fall && tx_armed) begin
      so_q <= tx_sr[7];
      tx_sr <= {tx_sr[6:0], 1'b0};
      drive_on <= 1'b1;
    end
  end
  assign LINK.so = so_q;
  assign LINK.so_oe_n = ~(drive_on & ~paused);

  // ************************************************
  // User-side outputs
  // ************************************************
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      STANDBY_O <= 1'b0;
    end else begin
      STANDBY_O <= cs_n_s & ~nv_write_pending;
    end
  end
  assign WIPER_O = wiper;
  assign NV_WRITE_PENDING_O = nv_write_pending;

  spw_tap_decode u_tap (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .position_i(wiper),
    .tap_select_o(TAP_SELECT_O)
  );
endmodule // spw_device
`default_nettype wire

/* spw_host.sv */
// Controller end: AXI4-Lite registers driving the serial wiper link
`timescale 1ns/10ps
`default_nettype none
`include "spw_map.svh"
module spw_host (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  spw_if.host LINK,
  input wire logic [`SPW_AXI_AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [`SPW_AXI_AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  import spw_pkg::*;

  // ************************************************
  // AXI4-Lite register slave
  // ************************************************
  logic aw_hold;
  logic w_hold;
  logic [`SPW_AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [31:0] cmd;
  logic [1:0] ctrl;
  logic [9:0] rdata;
  logic wr_fire;
  logic cmd_start;
  spw_host_state_t hstate;
  assign S_AXI_AWREADY_O = ~aw_hold & ~S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = ~w_hold & ~S_AXI_BVALID_O;
  assign wr_fire = aw_hold & w_hold;
  // Strobes are not used: every write replaces the whole word
  assign cmd_start = wr_fire && aw_addr == `SPW_REG_CMD && hstate == HS_IDLE;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `SPW_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA_I;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= (aw_addr[1:0] == 2'h0 && aw_addr <= `SPW_REG_CTRL) ? `SPW_RESP_OKAY : `SPW_RESP_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cmd <= 32'h00000000;
      ctrl <= 2'h0;
    end else if (wr_fire && aw_addr == `SPW_REG_CTRL) begin
      ctrl <= w_data[1:0];
    end else if (cmd_start) begin
      cmd <= w_data;
    end
  end

  assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= `SPW_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= `SPW_RESP_OKAY;
      case (S_AXI_ARADDR_I)
        `SPW_REG_CMD: S_AXI_RDATA_O <= cmd;
        `SPW_REG_STATUS: S_AXI_RDATA_O <= {31'h00000000, hstate != HS_IDLE};
        `SPW_REG_RDATA: S_AXI_RDATA_O <= {22'h000000, rdata};
        `SPW_REG_CTRL: S_AXI_RDATA_O <= {30'h00000000, ctrl};
        default: begin
          S_AXI_RDATA_O <= 32'h00000000;
          S_AXI_RRESP_O <= `SPW_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // ************************************************
  // Serial engine
  // ************************************************
  logic so_s1;
  logic so_s2;
  logic [3:0] timer;
  logic [5:0] nbits;
  logic [31:0] tx_sr;
  logic [31:0] rx_sr;
  logic tick;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      so_s1 <= 1'b0;
      so_s2 <= 1'b0;
    end else begin
      so_s1 <= LINK.so;
      so_s2 <= so_s1;
    end
  end
  // Half period well above the device's sampling delay in both directions
  assign tick = (timer == `SPW_HALF_CYC - 4'h1) && LINK.pause_n;

  // Pause only moves while the clock is low
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      LINK.pause_n <= 1'b1;
      LINK.write_guard_n <= 1'b1;
    end else begin
      LINK.write_guard_n <= ~ctrl[`SPW_CTRL_GUARD];
      // A tick raises sck on this edge, so pause waits for the next low phase
      if (!LINK.sck && !tick) begin
        LINK.pause_n <= ~(ctrl[`SPW_CTRL_PAUSE] && hstate == HS_SHIFT);
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      hstate <= HS_IDLE;
      LINK.cs_n <= 1'b1;
      LINK.sck <= 1'b0;
      LINK.si <= 1'b0;
      timer <= 4'h0;
      nbits <= 6'h00;
      tx_sr <= 32'h00000000;
      rx_sr <= 32'h00000000;
      rdata <= 10'h000;
    end else begin
      timer <= tick ? 4'h0 : (LINK.pause_n ? timer + 4'h1 : timer);
      case (hstate)
        HS_IDLE: begin
          timer <= 4'h0;
          if (cmd_start) begin
            tx_sr <= {w_data[7:0], w_data[15:8], w_data[23:16], 6'h00, w_data[25:24]};
            LINK.si <= w_data[7];
            nbits <= w_data[`SPW_CMD_LONG] ? 6'h20 : 6'h10;
            LINK.cs_n <= 1'b0;
            hstate <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          if (tick) begin
            hstate <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          if (tick && !LINK.sck) begin
            LINK.sck <= 1'b1;
            rx_sr <= {rx_sr[30:0], so_s2};
          end else if (tick) begin
            LINK.sck <= 1'b0;
            tx_sr <= {tx_sr[30:0], 1'b0};
            LINK.si <= tx_sr[30];
            nbits <= nbits - 6'h01;
            if (nbits == 6'h01) begin
              hstate <= HS_TAIL;
            end
          end
        end
        HS_TAIL: begin
          if (tick) begin
            LINK.cs_n <= 1'b1;
            rdata <= {rx_sr[1:0], rx_sr[15:8]};
            hstate <= HS_IDLE;
          end
        end
        default: hstate <= HS_IDLE;
      endcase
    end
  end
endmodule // spw_host
`default_nettype wire

/* spw_checker.sv */
// Checker for the serial wiper link, watching the wires between both ends
`timescale 1ns/10ps
`default_nettype none
module spw_checker (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic pause_n,
  input wire logic so,
  input wire logic so_oe_n
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // ****************************************
  // Link properties
  // ****************************************
  property p_so_on_fall;
    (!so_oe_n && $changed(so)) |-> !sck;
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("so changed while sck high");
  property p_si_stable_high;
    (!cs_n && $changed(si)) |-> !sck;
  endproperty
  a_si_stable_high: assert property (p_si_stable_high) else $error("si changed while sck high");
  property p_half_period;
    ($changed(sck) && pause_n) |=> $stable(sck) [*7];
  endproperty
  a_half_period: assert property (p_half_period) else $error("sck half period too short");
  property p_pause_sck_low;
    $changed(pause_n) |-> !sck;
  endproperty
  a_pause_sck_low: assert property (p_pause_sck_low) else $error("pause moved while sck high");
  // Output must sit off and frozen once the pause has settled in
  property p_pause_freeze;
    !pause_n [*5] |-> so_oe_n && $stable(so);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) else $error("output active during pause");
  property p_oe_off_deselected;
    cs_n [*6] |-> so_oe_n;
  endproperty
  a_oe_off_deselected: assert property (p_oe_off_deselected) else $error("so driven while deselected");
  property p_oe_only_selected;
    !so_oe_n |-> !cs_n;
  endproperty
  a_oe_only_selected: assert property (p_oe_only_selected) else $error("so driven with cs_n high");
  property p_lead_in;
    $fell(cs_n) |-> !sck [*8];
  endproperty
  a_lead_in: assert property (p_lead_in) else $error("sck moved too soon after select");
  property p_sck_idle;
    cs_n [*2] |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck not idle low outside frame");
endmodule // spw_checker
`default_nettype wire

/* serial_pot_wiper_control_test.sv */
// Self-checking bench: controller and wiper device joined over the serial link
`timescale 1ns/10ps
`default_nettype none
`include "spw_map.svh"
module serial_pot_wiper_control_test;
  localparam logic [3:0] DT = 4'h9; // Arbitrary device type value
  localparam int NV = 800; // Long enough that a status read lands inside a save
  logic ref_clk, rst, strap1, strap0;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr, br;
  logic [9:0] wiper;
  logic [1023:0] tap;
  logic pend, stby;
  int fail_count, n_compared;
  logic [9:0] vals [4] = '{10'h35A, 10'h249, 10'h138, 10'h3C7};
  spw_if link();
  spw_device #(.DEV_TYPE(DT), .NV_WRITE_CYC(NV)) spw_device_i (.REF_CLK_I(ref_clk), .RST_I(rst), .LINK(link),
    .ADDR_STRAP_1_I(strap1), .ADDR_STRAP_0_I(strap0), .WIPER_O(wiper), .TAP_SELECT_O(tap),
    .NV_WRITE_PENDING_O(pend), .STANDBY_O(stby));
  spw_host spw_host_i (.REF_CLK_I(ref_clk), .RST_I(rst), .LINK(link), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
  spw_checker spw_checker_i (.REF_CLK_I(ref_clk), .RST_I(rst), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .pause_n(link.pause_n), .so(link.so), .so_oe_n(link.so_oe_n));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // Two-byte copies clear the length flag, every other op sends four bytes
  task automatic start(input logic [3:0] opc, input logic [1:0] sel, input logic [9:0] d, input logic s1);
    logic [7:0] b1, b2;
    b1 = {DT, s1, 1'b0, 1'b0, opc[3]};
    b2 = {opc[2:0], 1'b0, sel, 2'h0};
    axi_wr(`SPW_REG_CMD, {(opc != `SPW_OP_CP_SET_WIPER && opc != `SPW_OP_CP_WIPER_SET), 5'h00, d, b2, b1});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      axi_rd(`SPW_REG_STATUS);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    chk("busy", {31'h0, rd[0]}, 32'h0);
    // The device sees the select rise only after its pin synchroniser
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic run(input logic [3:0] opc, input logic [1:0] sel, input logic [9:0] d, input logic s1 = 1'b1);
    start(opc, sel, d, s1);
    wait_idle();
  endtask
  task automatic wait_nv();
    int n;
    n = 0;
    while (pend !== 1'b0 && n < NV + 10) begin
      @(posedge ref_clk);
      n++;
    end
    chk("nv_done", {31'h0, pend}, 32'h0);
  endtask
  task automatic rd_result(input string nm, input logic [9:0] exp);
    axi_rd(`SPW_REG_RDATA);
    chk(nm, {22'h0, rd[9:0]}, {22'h0, exp});
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {rst, strap1, strap0} = 3'h6;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("wiper_rst", {22'h0, wiper}, 32'h0);
    chk("tap_rst", {31'h0, tap === 1024'h1}, 32'h1);
    chk("standby", {31'h0, stby}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      run(`SPW_OP_WR_SET, k[1:0], vals[k]);
      chk("pending", {31'h0, pend}, 32'h1);
      if (k == 0) begin
        run(`SPW_OP_RD_STATUS, 2'h0, 10'h000);
        rd_result("status", 10'h001);
      end
      wait_nv();
    end
    for (int k = 0; k < 4; k++) begin
      run(`SPW_OP_RD_SET, k[1:0], 10'h000);
      rd_result("setting", vals[k]);
    end
    for (int k = 0; k < 4; k++) begin
      run(`SPW_OP_CP_SET_WIPER, k[1:0], 10'h000);
      chk("wiper_copy", {22'h0, wiper}, {22'h0, vals[k]});
      chk("tap_copy", {31'h0, tap === (1024'h1 << vals[k])}, 32'h1);
    end
    run(`SPW_OP_WR_WIPER, 2'h0, 10'h2A5);
    chk("wiper_wr", {22'h0, wiper}, 32'h2A5);
    run(`SPW_OP_RD_WIPER, 2'h0, 10'h000);
    rd_result("wiper_rd", 10'h2A5);
    run(`SPW_OP_CP_WIPER_SET, 2'h1, 10'h000);
    wait_nv();
    run(`SPW_OP_RD_SET, 2'h1, 10'h000);
    rd_result("copy_back", 10'h2A5);
    // Guard low through the whole sequence must leave the setting alone
    axi_wr(`SPW_REG_CTRL, 32'h2);
    chk("wr_okay", {30'h0, br}, {30'h0, `SPW_RESP_OKAY});
    run(`SPW_OP_WR_SET, 2'h3, 10'h0F0);
    chk("guard_pend", {31'h0, pend}, 32'h0);
    axi_wr(`SPW_REG_CTRL, 32'h0);
    repeat (NV) @(posedge ref_clk);
    run(`SPW_OP_RD_SET, 2'h3, 10'h000);
    rd_result("guarded", vals[3]);
    run(`SPW_OP_WR_WIPER, 2'h0, 10'h111, 1'b0);
    chk("addr_miss", {22'h0, wiper}, 32'h2A5);
    start(`SPW_OP_WR_WIPER, 2'h0, 10'h0F0, 1'b1);
    repeat (120) @(posedge ref_clk);
    axi_wr(`SPW_REG_CTRL, 32'h1);
    repeat (800) @(posedge ref_clk);
    axi_rd(`SPW_REG_STATUS);
    chk("paused_busy", {31'h0, rd[0]}, 32'h1);
    chk("paused_wiper", {22'h0, wiper}, 32'h2A5);
    axi_wr(`SPW_REG_CTRL, 32'h0);
    wait_idle();
    chk("resumed", {22'h0, wiper}, 32'h0F0);
    axi_rd(5'h10);
    chk("unmapped", {rr, rd[29:0]}, {`SPW_RESP_SLVERR, 30'h0});
    axi_wr(5'h10, 32'h0);
    chk("wr_unmapped", {30'h0, br}, {30'h0, `SPW_RESP_SLVERR});
    tally_and_finish();
  end
endmodule // serial_pot_wiper_control_test
`default_nettype wire
